// ===== rtl/hso_option_regs.sv
`timescale 1ns/100ps
`include "hso_consts.svh"
// Contract
// R1: axis code 00 scans, 01/10/11 hold X/Y/Z
// R2: scan steps per resolution rate, else hold
// R3: SP clear: own pins, any chip select
// R4: SP set: ready pin floats, muxed on serial-out
// R5: host sets PO whenever it sets SP
// R6: PO clear: serial-out floats while deselected; code still drives it while deselected if SP is set
// R7: PO set: serial-out driven while idle
// R8: option bit 2 selects low power
// R9: option bit 3 reverses bias, mirrors codes
// R10: option bit 4 doubles analog clock
// R11: option bit 5 widens range thirty percent
// R12: option bit 7 multiplies range by ten
// R13: temp slope field bits 3-6, default 0001
// R14: word: write 13, read 12, ones, reg, value
// R15: measurement and option reset to zero
// R16: options apply next conversion, pins immediately
module hso_option_regs #(
   parameter int REFRESH_CYC = `HSO_REFRESH_CYC
) (
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   input  wire logic              spi_sclk_i,
   input  wire logic              spi_cs_n_i,
   input  wire logic              spi_mosi_i,
   input  wire logic              sample_ready_flag_i,
   input  wire logic [15:0]       sample_word_i,
   output logic                   spi_miso_o,
   output logic                   spi_miso_oe_n_o,
   output logic                   ready_pin_o,
   output logic                   ready_pin_oe_n_o,
   output hso_pkg::hso_front_t    front_o,
   output hso_pkg::hso_axis_t     axis_o,
   output logic                   conv_start_o
);
   logic [2:0]  sclk_s_r;
   logic [2:0]  cs_s_r;
   logic [2:0]  mosi_s_r;
   logic [7:0]  meas_r;
   logic [7:0]  opt_r;
   logic [7:0]  tc_r;
   logic [15:0] shin_r;
   logic [15:0] shout_r;
   logic [4:0]  bitcnt_r;
   logic [18:0] conv_cnt_r;
   logic [18:0] conv_last;
   logic        sclk_lvl_r;
   logic        cs_lvl_r;
   logic        sample_bit_r;
   logic        cs_n;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_fall;
   logic        word_done;
   logic [15:0] word;
   logic        status_sel;
   logic        always_drv;
   hso_pkg::hso_axis_t axis_r;

   function automatic logic [7:0] reg_read(input logic [1:0] idx, input logic [7:0] m,
                                           input logic [7:0] o, input logic [7:0] t);
      if (idx == `HSO_REG_MEAS) begin
         reg_read = m;
      end else if (idx == `HSO_REG_OPT) begin
         reg_read = o;
      end else if (idx == `HSO_REG_TC) begin
         reg_read = t;
      end else begin
         reg_read = 8'h00;
      end
   endfunction

   // three stages; only the agreeing later two are looked at
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sclk_s_r <= 3'h0;
         cs_s_r   <= 3'h7;
         mosi_s_r <= 3'h0;
      end else begin
         sclk_s_r <= {sclk_s_r[1:0], spi_sclk_i};
         cs_s_r   <= {cs_s_r[1:0], spi_cs_n_i};
         mosi_s_r <= {mosi_s_r[1:0], spi_mosi_i};
      end
   end

   // a level counts only once the last two stages agree; costs one cycle of latency
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sclk_lvl_r <= 1'b0;
         cs_lvl_r   <= 1'b1;
      end else begin
         if (sclk_s_r[2] == sclk_s_r[1]) begin
            sclk_lvl_r <= sclk_s_r[2];
         end
         if (cs_s_r[2] == cs_s_r[1]) begin
            cs_lvl_r <= cs_s_r[2];
         end
      end
   end

   assign cs_n      = cs_lvl_r;
   assign sclk_rise = (sclk_s_r[2:1] == 2'h3) && !sclk_lvl_r && !cs_n;
   assign sclk_fall = (sclk_s_r[2:1] == 2'h0) && sclk_lvl_r && !cs_n;
   assign cs_fall   = (cs_s_r[2:1] == 2'h0) && cs_lvl_r;
   assign word      = {shin_r[14:0], mosi_s_r[2]};
   assign word_done = sclk_rise && (bitcnt_r == 5'h0F);

   always_ff @(posedge core_clk_i) begin
      if (rst_i || cs_n) begin
         bitcnt_r <= 5'h00;
         shin_r   <= 16'h0000;
      end else if (sclk_rise) begin
         shin_r   <= word;
         bitcnt_r <= (bitcnt_r == 5'h0F) ? 5'h00 : bitcnt_r + 5'h01;
      end
   end

   // register writes, decoded on the completed word [R14]
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         meas_r <= `HSO_RST_MEAS; // [R15]
         opt_r  <= `HSO_RST_OPT; // [R15]
         tc_r   <= `HSO_RST_TC; // [R13]
      end else if (word_done && word[`HSO_CMD_WR_BIT] && (word[11:10] == `HSO_CMD_ONES)) begin // [R14]
         if (word[9:8] == `HSO_REG_MEAS) begin
            meas_r <= word[7:0];
         end else if (word[9:8] == `HSO_REG_OPT) begin
            opt_r <= word[7:0];
         end else if (word[9:8] == `HSO_REG_TC) begin
            tc_r <= word[7:0];
         end
      end
   end

   // readback queued for the next word, sample otherwise
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         shout_r <= 16'h0000;
      end else if (word_done && word[`HSO_CMD_RD_BIT] && (word[11:10] == `HSO_CMD_ONES)) begin // [R14]
         shout_r <= {8'h00, reg_read(word[9:8], meas_r, opt_r, tc_r)};
      end else if (cs_fall) begin
         shout_r <= sample_word_i;
      end else if (sclk_fall) begin
         shout_r <= {shout_r[14:0], 1'b0};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sample_bit_r <= 1'b0;
      end else begin
         sample_bit_r <= shout_r[15];
      end
   end

   // conversion pacing; settings latch only at a conversion boundary
   // each resolution step halves the rate; the latched field sets it [R2]
   assign conv_last = (19'(REFRESH_CYC) << front_o.conversion_resolution) - 19'h00001;

   always_ff @(posedge core_clk_i) begin
      if (rst_i || conv_cnt_r >= conv_last) begin
         conv_cnt_r <= 19'h00000;
      end else begin
         conv_cnt_r <= conv_cnt_r + 19'h00001;
      end
   end

   assign conv_start_o = (conv_cnt_r == 19'h00000) && !rst_i;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         front_o <= '0;
         front_o.temp_slope <= `HSO_TC_DEFAULT;
      end else if (conv_start_o) begin // [R16]
         front_o.range_times_ten       <= opt_r[`HSO_OPT_LMR]; // [R12]
         front_o.range_plus_thirty     <= opt_r[`HSO_OPT_EMR]; // [R11]
         front_o.analog_clock_double   <= opt_r[`HSO_OPT_HC]; // [R10]
         front_o.bias_reverse          <= opt_r[`HSO_OPT_INV]; // [R9]
         front_o.low_power_select      <= opt_r[`HSO_OPT_LP]; // [R8]
         front_o.axis_select           <= meas_r[`HSO_AXIS_LSB +: 2]; // [R1]
         front_o.field_range           <= meas_r[`HSO_RANGE_LSB +: 2];
         front_o.conversion_resolution <= meas_r[`HSO_RES_LSB +: 2];
         front_o.temp_slope            <= tc_r[`HSO_TC_LSB +: 4]; // [R13]
      end
   end

   // scan steps X,Y,Z one axis per conversion; fixed code holds one axis
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         axis_r <= hso_pkg::HSO_AX_X;
      end else if (conv_start_o) begin
         case (meas_r[`HSO_AXIS_LSB +: 2]) // [R1]
            2'h1: axis_r <= hso_pkg::HSO_AX_X;
            2'h2: axis_r <= hso_pkg::HSO_AX_Y;
            2'h3: axis_r <= hso_pkg::HSO_AX_Z;
            default: begin
               case (axis_r) // [R2]
                  hso_pkg::HSO_AX_X: axis_r <= hso_pkg::HSO_AX_Y;
                  hso_pkg::HSO_AX_Y: axis_r <= hso_pkg::HSO_AX_Z;
                  default:           axis_r <= hso_pkg::HSO_AX_X;
               endcase
            end
         endcase
      end
   end

   assign axis_o = axis_r;

   // routing follows the register at once, no conversion wait [R16]
   assign status_sel = opt_r[`HSO_OPT_SP];
   // sp alone also keeps serial-out driven on idle bus; host keeps po set [R5]
   assign always_drv = opt_r[`HSO_OPT_PO] || status_sel;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         spi_miso_o       <= 1'b0;
         spi_miso_oe_n_o  <= 1'b1;
         ready_pin_o      <= 1'b0;
         ready_pin_oe_n_o <= 1'b1;
      end else begin
         ready_pin_o      <= sample_ready_flag_i;
         ready_pin_oe_n_o <= status_sel; // [R3] [R4]
         spi_miso_o       <= (status_sel && cs_n) ? sample_ready_flag_i : sample_bit_r; // [R4]
         spi_miso_oe_n_o  <= cs_n && !always_drv; // [R6] [R7]
      end
   end
endmodule

// ===== rtl/hso_consts.svh
`ifndef HSO_CONSTS_SVH
`define HSO_CONSTS_SVH
`define HSO_REG_MEAS       2'h0
`define HSO_REG_OPT        2'h1
`define HSO_REG_TC         2'h2
`define HSO_RST_MEAS       8'h00
`define HSO_RST_OPT        8'h00
`define HSO_RST_TC         8'h08
`define HSO_CMD_WR_BIT     13
`define HSO_CMD_RD_BIT     12
`define HSO_CMD_ONES       2'h3
`define HSO_AXIS_LSB       6
`define HSO_RES_LSB        4
`define HSO_RANGE_LSB      2
`define HSO_OUTSEL_LSB     0
`define HSO_OPT_SP         0
`define HSO_OPT_PO         1
`define HSO_OPT_LP         2
`define HSO_OPT_INV        3
`define HSO_OPT_HC         4
`define HSO_OPT_EMR        5
`define HSO_OPT_LMR        7
`define HSO_TC_LSB         3
`define HSO_TC_DEFAULT     4'h1
`define HSO_REFRESH_3K_NS  333333
`define HSO_CLK_NS         10
`define HSO_REFRESH_CYC    (`HSO_REFRESH_3K_NS / `HSO_CLK_NS)
`endif

// ===== rtl/hso_pkg.sv
package hso_pkg;
   typedef enum logic [3:0] {
      HSO_AX_X    = 4'h1,
      HSO_AX_Y    = 4'h2,
      HSO_AX_Z    = 4'h4,
      HSO_AX_IDLE = 4'h8
   } hso_axis_t;

   typedef struct packed {
      logic       range_times_ten;
      logic       range_plus_thirty;
      logic       analog_clock_double;
      logic       bias_reverse;
      logic       low_power_select;
      logic [1:0] axis_select;
      logic [1:0] field_range;
      logic [1:0] conversion_resolution;
      logic [3:0] temp_slope;
   } hso_front_t;
endpackage

// ===== test/hso_option_regs_properties.sv
`timescale 1ns/100ps
module hso_option_regs_properties (
   input wire logic                core_clk_i,
   input wire logic                rst_i,
   input wire logic                spi_cs_n_i,
   input wire logic                sample_ready_flag_i,
   input wire logic                spi_miso_o,
   input wire logic                spi_miso_oe_n_o,
   input wire logic                ready_pin_o,
   input wire logic                ready_pin_oe_n_o,
   input wire hso_pkg::hso_front_t front_o,
   input wire hso_pkg::hso_axis_t  axis_o,
   input wire logic                conv_start_o
);
   default clocking dc @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   // six idle cycles cover the three-stage chip-select sync
   sequence s_idle_sp;
      (spi_cs_n_i && ready_pin_oe_n_o && $stable(sample_ready_flag_i))[*6];
   endsequence
   sequence s_scan_step;
      conv_start_o && front_o.axis_select == 2'h0 ##1 (front_o.axis_select == 2'h0)[*4];
   endsequence
   property p_ready_pin; !ready_pin_oe_n_o |-> ready_pin_o == $past(sample_ready_flag_i); endproperty
   property p_miso_status; s_idle_sp |-> spi_miso_o == sample_ready_flag_i; endproperty
   property p_miso_driven; s_idle_sp |-> !spi_miso_oe_n_o; endproperty
   property p_reset_vals;
      disable iff (1'b0) rst_i |=> front_o == 15'h0001 && axis_o == hso_pkg::HSO_AX_X && ready_pin_oe_n_o;
   endproperty
   property p_axis_hold;
      (front_o.axis_select != 2'h0 && $stable(front_o.axis_select))[*3] |->
         axis_o == 4'h1 << (front_o.axis_select - 2'h1);
   endproperty
   property p_axis_scan; s_scan_step |-> axis_o != $past(axis_o, 5); endproperty
   property p_conv_pulse; conv_start_o |=> (!conv_start_o)[*8]; endproperty
   property p_front_hold; $changed(front_o) |-> conv_start_o || $past(conv_start_o) || $past(rst_i); endproperty
   a_ready_pin: assert property (p_ready_pin) else $error("ready pin wrong");
   a_miso_status: assert property (p_miso_status) else $error("status on miso wrong");
   a_miso_driven: assert property (p_miso_driven) else $error("miso not driven");
   a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
   a_axis_hold: assert property (p_axis_hold) else $error("held axis wrong");
   a_axis_scan: assert property (p_axis_scan) else $error("scan stalled");
   a_conv_pulse: assert property (p_conv_pulse) else $error("conversion pulse too long");
   a_front_hold: assert property (p_front_hold) else $error("settings changed mid conversion");
endmodule
bind hso_option_regs hso_option_regs_properties u_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .spi_cs_n_i(spi_cs_n_i), .sample_ready_flag_i(sample_ready_flag_i), .spi_miso_o(spi_miso_o),
   .spi_miso_oe_n_o(spi_miso_oe_n_o), .ready_pin_o(ready_pin_o), .ready_pin_oe_n_o(ready_pin_oe_n_o),
   .front_o(front_o), .axis_o(axis_o), .conv_start_o(conv_start_o));

// ===== test/hso_spi_host.sv
`timescale 1ns/100ps
module hso_spi_host (
   input  wire logic core_clk_i,
   input  wire logic miso_i,
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task automatic half();
      repeat (4) @(negedge core_clk_i);
   endtask
   // clock idles low outside frames; reply bit caught before each rise
   // keep leaves chip select low so the next word joins the same frame
   task automatic xfer(input logic [15:0] w, input logic keep, output logic [15:0] r);
      cs_n_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi_o = w[i];
         half();
         r[i] = miso_i;
         sclk_o = 1'b1;
         half();
         sclk_o = 1'b0;
      end
      if (!keep) begin
         half();
         cs_n_o = 1'b1;
         mosi_o = ~mosi_o;
         half();
      end
   endtask
endmodule

// ===== test/hso_option_regs_bench.sv
`timescale 1ns/100ps
module hso_option_regs_bench;
   logic                clk, rst, flag, sclk, cs_n, mosi, miso, miso_w, miso_oe_n, rdy, rdy_oe_n, conv;
   hso_pkg::hso_front_t fr;
   hso_pkg::hso_axis_t  ax;
   logic [15:0]         r;
   int                  bad_count = 0;
   int                  check_count = 0;
   int                  n;
   // floating line shows the inverse, never a stale value
   assign miso_w = miso_oe_n ? ~miso : miso;
   hso_option_regs #(.REFRESH_CYC(20)) uut (.core_clk_i(clk), .rst_i(rst), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
      .spi_mosi_i(mosi), .sample_ready_flag_i(flag), .sample_word_i(16'h0000), .spi_miso_o(miso),
      .spi_miso_oe_n_o(miso_oe_n), .ready_pin_o(rdy), .ready_pin_oe_n_o(rdy_oe_n), .front_o(fr), .axis_o(ax),
      .conv_start_o(conv));
   hso_spi_host host (.core_clk_i(clk), .miso_i(miso_w), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      host.xfer({4'h2, 2'h3, a, v}, 1'b0, r);
   endtask
   // answer comes in the following word of the same frame; a new frame reloads the sample
   task automatic rd(input logic [1:0] a, input logic [7:0] e, input string n);
      host.xfer({4'h1, 2'h3, a, 8'h00}, 1'b1, r);
      host.xfer({4'h1, 2'h3, a, 8'h00}, 1'b0, r);
      chk(n, {8'h00, e}, r);
   endtask
   task automatic pins(input logic f, input logic [15:0] e, input string n);
      flag = f;
      repeat (10) @(negedge clk);
      chk(n, e, {12'h000, rdy_oe_n, rdy, miso_oe_n, miso});
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      test_done();
   end
   initial begin
      rst = 1'b1;
      flag = 1'b0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      rd(2'h0, 8'h00, "meas reset");
      rd(2'h1, 8'h00, "opt reset");
      rd(2'h2, 8'h08, "tc reset");
      pins(1'b1, 16'h0006, "sp off po off");
      wr(2'h1, 8'h03);
      pins(1'b1, 16'h000D, "status high");
      pins(1'b0, 16'h0008, "status low");
      rd(2'h1, 8'h03, "opt data cs low");
      wr(2'h1, 8'h02);
      pins(1'b1, 16'h0004, "po only");
      host.xfer({4'h2, 2'h2, 2'h1, 8'h55}, 1'b0, r);
      rd(2'h1, 8'h02, "bad word refused");
      wr(2'h1, 8'hBC);
      wr(2'h2, 8'h78);
      repeat (50) @(negedge clk);
      chk("front", 16'h7C0F, {1'b0, fr});
      for (int a = 1; a < 4; a++) begin
         wr(2'h0, {a[1:0], 6'h00});
         repeat (50) @(negedge clk);
         chk("axis", 16'h0001 << (a - 1), {12'h000, ax});
      end
      wr(2'h0, 8'h30);
      repeat (200) @(negedge clk);
      while (!conv) @(negedge clk);
      @(negedge clk);
      n = 1;
      while (!conv) begin
         @(negedge clk);
         n++;
      end
      chk("period", 16'h00A0, n[15:0]);
      wr(2'h0, 8'h00);
      repeat (100) @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      rd(2'h1, 8'h00, "opt second reset");
      test_done();
   end
endmodule
